// file: logic/cpu_bus_end.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_end (
  input wire logic clock,
  input wire logic sys_rst,
  mem_bus_if.cpu bus,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [mem_glue_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [mem_glue_pkg::DATA_W-1:0] reqData,
  output logic reqReady,
  output logic rspValid,
  output logic [mem_glue_pkg::DATA_W-1:0] rspData
);

  typedef enum logic [1:0] {CPU_IDLE, CPU_SETUP, CPU_STROBE, CPU_FINISH} cpu_state_e;

  cpu_state_e state_r, state_nxt;
  logic write_r, write_nxt;
  logic [mem_glue_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [mem_glue_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [mem_glue_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
  logic wdataOe_r, wdataOe_nxt;
  logic [mem_glue_pkg::STROBE_CNT_W-1:0] strobeCnt_r, strobeCnt_nxt;
  logic reqReady_r, reqReady_nxt;
  logic rspValid_r, rspValid_nxt;
  logic [mem_glue_pkg::DATA_W-1:0] rspData_r, rspData_nxt;

  // bus cycle sequencer: setup, strobe until ready, release
  always_comb
  begin
    state_nxt = state_r;
    write_nxt = write_r;
    addr_nxt = addr_r;
    ctrl_nxt = ctrl_r;
    wdata_nxt = wdata_r;
    wdataOe_nxt = wdataOe_r;
    strobeCnt_nxt = strobeCnt_r;
    reqReady_nxt = reqReady_r;
    rspValid_nxt = 1'b0;
    rspData_nxt = rspData_r;
    case (state_r)
      CPU_IDLE:
      begin
        if (reqValid && reqReady_r)
        begin
          state_nxt = CPU_SETUP;
          write_nxt = reqWrite;
          addr_nxt = reqAddr;
          wdata_nxt = reqData;
          wdataOe_nxt = reqWrite;
          reqReady_nxt = 1'b0;
        end
      end
      CPU_SETUP:
      begin
        state_nxt = CPU_STROBE;
        strobeCnt_nxt = mem_glue_pkg::STROBE_CNT_W'(mem_glue_pkg::STROBE_MIN_CYCLES - 1);
        if (write_r)
        begin
          ctrl_nxt[mem_glue_pkg::CTRL_MEM_WRITE_N] = 1'b0;
        end
        else
        begin
          ctrl_nxt[mem_glue_pkg::CTRL_MEM_READ_N] = 1'b0;
          ctrl_nxt[mem_glue_pkg::CTRL_DATA_BUS_IN] = 1'b1;
        end
      end
      CPU_STROBE:
      begin
        if (strobeCnt_r != '0)
        begin
          strobeCnt_nxt = strobeCnt_r - 1'b1;
        end
        else if (bus.ready)
        begin
          state_nxt = CPU_FINISH;
          ctrl_nxt = mem_glue_pkg::CTRL_IDLE;
          if (!write_r)
          begin
            rspData_nxt = bus.dataBus;
          end
        end
        // ready low holds the strobe: wait sequence
      end
      CPU_FINISH:
      begin
        state_nxt = CPU_IDLE;
        wdataOe_nxt = 1'b0;
        rspValid_nxt = 1'b1;
        reqReady_nxt = 1'b1;
      end
      default:
      begin
        state_nxt = CPU_IDLE;
        ctrl_nxt = mem_glue_pkg::CTRL_IDLE;
        wdataOe_nxt = 1'b0;
        reqReady_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= CPU_IDLE;
      write_r <= 1'b0;
      addr_r <= mem_glue_pkg::ADDR_RESET;
      ctrl_r <= mem_glue_pkg::CTRL_IDLE;
      wdata_r <= mem_glue_pkg::DATA_RESET;
      wdataOe_r <= 1'b0;
      strobeCnt_r <= '0;
      reqReady_r <= 1'b1;
      rspValid_r <= 1'b0;
      rspData_r <= mem_glue_pkg::DATA_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      write_r <= write_nxt;
      addr_r <= addr_nxt;
      ctrl_r <= ctrl_nxt;
      wdata_r <= wdata_nxt;
      wdataOe_r <= wdataOe_nxt;
      strobeCnt_r <= strobeCnt_nxt;
      reqReady_r <= reqReady_nxt;
      rspValid_r <= rspValid_nxt;
      rspData_r <= rspData_nxt;
    end
  end

  // bus and user outputs from flops
  assign bus.addr = addr_r;
  assign bus.ctrl = ctrl_r;
  assign bus.cpuData = wdata_r;
  assign bus.cpuDataOe = wdataOe_r;
  assign reqReady = reqReady_r;
  assign rspValid = rspValid_r;
  assign rspData = rspData_r;

endmodule // cpu_bus_end
`default_nettype wire

// file: logic/mem_array_end.sv
// Summary of operation
// - byte data, six control, sixteen address lines
// - rom low address bits, selects from A11/A12
// - rom drives addressed byte while read low
// - 4-bit rams pair into byte-wide storage
// - ram write by write strobe, disable by read
// - ram reads return data like rom
// - ram stores bus data on write strobe
// - slow memories request wait states
// - strobe to slow memory pulls ready low
// - ready returns high after memory time
// - wait count set by WAIT_COUNT parameter
`timescale 1ns/1ps
`default_nettype none
module mem_array_end #(
  parameter int WAIT_COUNT = mem_glue_pkg::WAIT_CYCLES,
  parameter bit USE_DATA_BUS_IN = 1'b0,
  parameter bit ROM_SLOW = 1'b1,
  parameter bit RAM_SLOW = 1'b1
) (
  input wire logic clock,
  input wire logic sys_rst,
  mem_bus_if.memory bus,
  output logic [mem_glue_pkg::ROM_CHIPS-1:0] romActive,
  output logic ramActive,
  output logic waitActive
);

  typedef enum logic [1:0] {READY_IDLE, READY_HOLD, READY_DONE} ready_state_e;

  logic memReadN;
  logic memWriteN;
  logic dataBusInStrobe;
  logic romReadGateSelect;
  logic ramOutputDisable;
  logic romRegion;
  logic ramRegion;
  logic [mem_glue_pkg::ROM_CHIPS-1:0] romSelect;
  logic [mem_glue_pkg::RAM_BANKS-1:0] ramBankSelect;
  logic slowHit;
  logic strobeLow;

  logic [mem_glue_pkg::DATA_W-1:0] ramStore [mem_glue_pkg::RAM_DEPTH];
  logic [mem_glue_pkg::DATA_W-1:0] ramRead;
  logic [mem_glue_pkg::DATA_W-1:0] romRead;
  logic ramWriteEnable;
  logic [mem_glue_pkg::RAM_ADDR_W:0] ramIndex;

  logic [mem_glue_pkg::DATA_W-1:0] memData_r, memData_nxt;
  logic memDataOe_r, memDataOe_nxt;
  logic writeSeen_r, writeSeen_nxt;
  logic [mem_glue_pkg::ROM_CHIPS-1:0] romActive_r, romActive_nxt;
  logic ramActive_r, ramActive_nxt;

  ready_state_e readyState_r, readyState_nxt;
  logic [mem_glue_pkg::WAIT_CNT_W-1:0] waitCnt_r, waitCnt_nxt;
  logic ready_r, ready_nxt;
  logic waitActive_r, waitActive_nxt;

  // rom contents as a fixed pattern of address and chip
  function automatic logic [mem_glue_pkg::DATA_W-1:0] romByte(input logic [mem_glue_pkg::ADDR_W-1:0] a);
    romByte = a[7:0] ^ {a[10:8], a[12:11], 3'h5};
  endfunction

  // control bus fields
  assign memReadN = bus.ctrl[mem_glue_pkg::CTRL_MEM_READ_N];
  assign memWriteN = bus.ctrl[mem_glue_pkg::CTRL_MEM_WRITE_N];
  assign dataBusInStrobe = bus.ctrl[mem_glue_pkg::CTRL_DATA_BUS_IN];

  // rom read gate and ram output disable
  assign romReadGateSelect = memReadN;
  assign ramOutputDisable = USE_DATA_BUS_IN ? ~dataBusInStrobe : memReadN;

  // region decode
  assign romRegion = (bus.addr[mem_glue_pkg::ADDR_W-1:mem_glue_pkg::ROM_REGION_LSB] == mem_glue_pkg::ROM_REGION);
  assign ramRegion = (bus.addr[mem_glue_pkg::ADDR_W-1:mem_glue_pkg::RAM_REGION_LSB] == mem_glue_pkg::RAM_REGION);

  // per-chip rom selects from the two high rom address bits
  generate
    for (genvar c = 0; c < mem_glue_pkg::ROM_CHIPS; c++)
    begin : g_rom_sel
      logic romRegionSelectLow;
      logic romRegionSelectHigh;
      assign romRegionSelectLow = (bus.addr[mem_glue_pkg::ROM_ADDR_W] == 1'(c % 2));
      assign romRegionSelectHigh = (bus.addr[mem_glue_pkg::ROM_ADDR_W + 1] == 1'(c / 2));
      assign romSelect[c] = romRegion & romRegionSelectLow & romRegionSelectHigh;
    end
  endgenerate

  // ram bank selects, each bank a pair of 4-bit chips
  generate
    for (genvar b = 0; b < mem_glue_pkg::RAM_BANKS; b++)
    begin : g_ram_sel
      assign ramBankSelect[b] = ramRegion & (bus.addr[mem_glue_pkg::RAM_ADDR_W] == 1'(b));
    end
  endgenerate

  // storage lookups
  assign ramIndex = bus.addr[mem_glue_pkg::RAM_ADDR_W:0];
  assign ramRead = ramStore[ramIndex];
  assign romRead = romByte({3'h0, bus.addr[mem_glue_pkg::ROM_ADDR_W+1:0]});

  // slow access detection
  assign strobeLow = ~memReadN | ~memWriteN;
  assign slowHit = strobeLow & ((romRegion & ROM_SLOW) | (ramRegion & RAM_SLOW));

  // data path: read gating and write capture
  always_comb
  begin
    memData_nxt = mem_glue_pkg::DATA_RESET;
    memDataOe_nxt = 1'b0;
    writeSeen_nxt = ~memWriteN;
    ramWriteEnable = 1'b0;
    romActive_nxt = romSelect & {mem_glue_pkg::ROM_CHIPS{strobeLow}};
    ramActive_nxt = (|ramBankSelect) & strobeLow;
    if (!romReadGateSelect && romRegion)
    begin
      memData_nxt = romRead;
      memDataOe_nxt = 1'b1;
    end
    else if (!ramOutputDisable && memWriteN && ramRegion)
    begin
      memData_nxt = ramRead;
      memDataOe_nxt = 1'b1;
    end
    if (!memWriteN && !writeSeen_r && ramRegion)
    begin
      ramWriteEnable = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      memData_r <= mem_glue_pkg::DATA_RESET;
      memDataOe_r <= 1'b0;
      writeSeen_r <= 1'b0;
      romActive_r <= '0;
      ramActive_r <= 1'b0;
    end
    else
    begin
      memData_r <= memData_nxt;
      memDataOe_r <= memDataOe_nxt;
      writeSeen_r <= writeSeen_nxt;
      romActive_r <= romActive_nxt;
      ramActive_r <= ramActive_nxt;
    end
  end

  // ram array, written on the falling write strobe
  always_ff @(posedge clock)
  begin
    if (ramWriteEnable)
    begin
      ramStore[ramIndex] <= bus.dataBus;
    end
  end

  // wait-state sequencer driving ready
  always_comb
  begin
    readyState_nxt = readyState_r;
    waitCnt_nxt = waitCnt_r;
    ready_nxt = ready_r;
    waitActive_nxt = waitActive_r;
    case (readyState_r)
      READY_IDLE:
      begin
        if (slowHit)
        begin
          readyState_nxt = READY_HOLD;
          waitCnt_nxt = mem_glue_pkg::WAIT_CNT_W'(WAIT_COUNT - 1);
          ready_nxt = 1'b0;
          waitActive_nxt = 1'b1;
        end
      end
      READY_HOLD:
      begin
        if (waitCnt_r == '0)
        begin
          readyState_nxt = READY_DONE;
          ready_nxt = 1'b1;
          waitActive_nxt = 1'b0;
        end
        else
        begin
          waitCnt_nxt = waitCnt_r - 1'b1;
        end
      end
      READY_DONE:
      begin
        if (!strobeLow)
        begin
          readyState_nxt = READY_IDLE;
        end
      end
      default:
      begin
        readyState_nxt = READY_IDLE;
        ready_nxt = 1'b1;
        waitActive_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      readyState_r <= READY_IDLE;
      waitCnt_r <= '0;
      ready_r <= 1'b1;
      waitActive_r <= 1'b0;
    end
    else
    begin
      readyState_r <= readyState_nxt;
      waitCnt_r <= waitCnt_nxt;
      ready_r <= ready_nxt;
      waitActive_r <= waitActive_nxt;
    end
  end

  // outputs straight from flops
  assign bus.memData = memData_r;
  assign bus.memDataOe = memDataOe_r;
  assign bus.ready = ready_r;
  assign romActive = romActive_r;
  assign ramActive = ramActive_r;
  assign waitActive = waitActive_r;

endmodule // mem_array_end
`default_nettype wire

// file: logic/mem_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mem_bus_if;
  logic [mem_glue_pkg::ADDR_W-1:0] addr;
  logic [mem_glue_pkg::CTRL_W-1:0] ctrl;
  logic [mem_glue_pkg::DATA_W-1:0] cpuData;
  logic cpuDataOe;
  logic [mem_glue_pkg::DATA_W-1:0] memData;
  logic memDataOe;
  logic ready;
  logic [mem_glue_pkg::DATA_W-1:0] dataBus;

  // resolved data bus level, pulled up when nobody drives
  assign dataBus = cpuDataOe ? cpuData : (memDataOe ? memData : mem_glue_pkg::BUS_PULLUP);

  modport cpu (output addr, output ctrl, output cpuData, output cpuDataOe, input ready, input dataBus);
  modport memory (input addr, input ctrl, input dataBus, output memData, output memDataOe, output ready);
endinterface
`default_nettype wire

// file: logic/mem_glue_pkg.sv
package mem_glue_pkg;

  // bus widths
  localparam int DATA_W = 8;
  localparam int CTRL_W = 6;
  localparam int ADDR_W = 16;

  // control bus bit positions
  localparam int CTRL_MEM_READ_N = 0;
  localparam int CTRL_MEM_WRITE_N = 1;
  localparam int CTRL_IO_READ_N = 2;
  localparam int CTRL_IO_WRITE_N = 3;
  localparam int CTRL_DATA_BUS_IN = 4;
  localparam int CTRL_INT_ACK_N = 5;

  // idle level of the control bus: strobes high, data-bus-in low
  localparam logic [CTRL_W-1:0] CTRL_IDLE = 6'h2F;

  // rom: four chips of 2k bytes, region at the bottom 8k
  localparam int ROM_CHIPS = 4;
  localparam int ROM_ADDR_W = 11;
  localparam int ROM_REGION_LSB = 13;
  localparam logic [2:0] ROM_REGION = 3'h0;

  // ram: two byte-wide banks of 256, built from 4-bit chips
  localparam int RAM_ADDR_W = 8;
  localparam int RAM_BANKS = 2;
  localparam int RAM_DEPTH = 512;
  localparam int RAM_REGION_LSB = 9;
  localparam logic [6:0] RAM_REGION = 7'h10;

  // timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int SLOW_ACCESS_NS = 850;
  localparam int WAIT_CYCLES = (SLOW_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WAIT_CNT_W = 9;
  localparam int STROBE_MIN_CYCLES = 3;
  localparam int STROBE_CNT_W = 2;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BUS_PULLUP = 8'hFF;

endpackage

// file: logic/README_NONE.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: testbench/mem_glue_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mem_glue_chk #(
  parameter int WAIT_COUNT = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [mem_glue_pkg::ADDR_W-1:0] addr,
  input wire logic [mem_glue_pkg::CTRL_W-1:0] ctrl,
  input wire logic cpuDataOe,
  input wire logic [mem_glue_pkg::DATA_W-1:0] memData,
  input wire logic memDataOe,
  input wire logic ready
);
  logic inRom;
  logic inRam;
  logic rdLow;
  logic wrLow;
  logic strobeIdle;
  logic [7:0] romByte;
  logic [8:0] lowCnt_r;
  logic [8:0] lowCnt_nxt;

  // region decode, strobes and expected rom byte
  assign inRom = addr[15:13] == 3'h0;
  assign inRam = addr[15:9] == 7'h10;
  assign rdLow = !ctrl[mem_glue_pkg::CTRL_MEM_READ_N];
  assign wrLow = !ctrl[mem_glue_pkg::CTRL_MEM_WRITE_N];
  assign strobeIdle = !rdLow && !wrLow;
  assign romByte = addr[7:0] ^ {addr[10:8], addr[12:11], 3'h5};

  // length of the current wait stretch
  always_comb
  begin
    lowCnt_nxt = ready ? 9'h000 : lowCnt_r + 9'h001;
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      lowCnt_r <= 9'h000;
    else
      lowCnt_r <= lowCnt_nxt;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  chk_wait_start: assert property ($fell(strobeIdle) && (inRom || inRam) |=> !ready)
    else $error("ready not pulled low by slow access");
  chk_wait_length: assert property ($rose(ready) |-> lowCnt_r == WAIT_COUNT)
    else $error("wait stretch has wrong length");
  chk_wait_bound: assert property (lowCnt_r <= WAIT_COUNT)
    else $error("wait stretch too long");
  chk_rom_gate: assert property (rdLow && !wrLow && inRom |=> memDataOe && memData == $past(romByte))
    else $error("rom byte not driven under read strobe");
  chk_ram_gate: assert property (rdLow && !wrLow && inRam |=> memDataOe)
    else $error("ram not driving under read strobe");
  chk_unmapped_quiet: assert property (!strobeIdle && !inRom && !inRam |=> !memDataOe && ready)
    else $error("unmapped access answered");
  chk_write_no_read: assert property (wrLow |=> !memDataOe)
    else $error("memory drives bus during write");
  chk_write_drives: assert property (wrLow |-> cpuDataOe)
    else $error("write strobe without write data");
  chk_idle_ready: assert property (strobeIdle |-> ready)
    else $error("ready low without strobe");
  chk_strobe_width: assert property ($fell(strobeIdle) |-> (!strobeIdle)[*3])
    else $error("strobe shorter than three cycles");

  // main scenarios reached
  cover property (rdLow && inRom);
  cover property (wrLow && inRam);
  cover property ($rose(ready));
endmodule // mem_glue_chk
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int WAITS = 4;
  localparam int LIMIT = 5000;
  typedef struct packed {logic rd; logic [7:0] d;} note_s;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [15:0] reqAddr = 16'h0000;
  logic [7:0] reqData = 8'h00;
  logic reqReady;
  logic rspValid;
  logic [7:0] rspData;
  logic [3:0] romActive;
  logic ramActive;
  logic waitActive;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 35;
  note_s notes[$];
  note_s got;
  logic [7:0] ramImg [logic [15:0]];

  mem_bus_if bus ();
  cpu_bus_end u_cpu_bus_end (.clock(clock), .sys_rst(sys_rst), .bus(bus), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData));
  mem_array_end #(.WAIT_COUNT(WAITS)) u_mem_array_end (.clock(clock), .sys_rst(sys_rst), .bus(bus),
    .romActive(romActive), .ramActive(ramActive), .waitActive(waitActive));
  mem_glue_chk #(.WAIT_COUNT(WAITS)) u_mem_glue_chk (.clock(clock), .sys_rst(sys_rst), .addr(bus.addr),
    .ctrl(bus.ctrl), .cpuDataOe(bus.cpuDataOe), .memData(bus.memData), .memDataOe(bus.memDataOe),
    .ready(bus.ready));

  always #2.5 clock = ~clock;

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic conclude;
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] romByte(input logic [15:0] a);
    return a[7:0] ^ {a[10:8], a[12:11], 3'h5};
  endfunction

  // one transfer; notes the expected read byte and checks the selects seen
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [3:0] sRom;
    logic sRam;
    sRom = 4'h0;
    sRam = 1'b0;
    notes.push_back({!wr, e});
    @(posedge clock);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqData <= d;
    @(posedge clock);
    reqValid <= 1'b0;
    repeat (400)
    begin
      @(negedge clock);
      sRom |= romActive;
      sRam |= ramActive;
      if (rspValid === 1'b1)
        break;
    end
    check("romActive", {4'h0, (a[15:13] == 3'h0) ? 4'h1 << a[12:11] : 4'h0}, {4'h0, sRom});
    check("ramActive", {7'h0, a[15:9] == 7'h10}, {7'h0, sRam});
    check("reqReady", 8'h01, {7'h0, reqReady});
  endtask

  // result watcher and wait flag watcher
  always @(negedge clock)
  begin
    if (!sys_rst)
      check("waitActive", {7'h0, !bus.ready}, {7'h0, waitActive});
    if (rspValid === 1'b1)
    begin
      got = notes.pop_front();
      if (got.rd)
        check("rspData", got.d, rspData);
    end
  end

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    logic [15:0] a;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      a = {3'h0, 2'(c), 11'($random(seed))};
      access(1'b0, a, 8'h00, romByte(a));
    end
    access(1'b1, 16'h0123, 8'hA5, 8'h00);
    access(1'b0, 16'h0123, 8'h00, romByte(16'h0123));
    ramImg[16'h2000] = 8'h3C;
    ramImg[16'h2100] = 8'hC3;
    ramImg[16'h21FF] = 8'h5A;
    repeat (8)
    begin
      a = 16'h2000 | (16'($random(seed)) & 16'h01FF);
      ramImg[a] = 8'($random(seed));
    end
    foreach (ramImg[k])
      access(1'b1, k, ramImg[k], 8'h00);
    foreach (ramImg[k])
      access(1'b0, k, 8'h00, ramImg[k]);
    access(1'b0, 16'h8000, 8'h00, 8'hFF);
    access(1'b1, 16'h4000, 8'h12, 8'h00);
    repeat (4) @(posedge clock);
    conclude();
  end
endmodule // testbench
`default_nettype wire
